/* hw/arf_consts.svh */
// Address map, field positions and reset values of the
// accumulator register bank.
// Assumes an APB slave with a 12-bit byte address and 32-bit data.
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH

// ****************************************************************
// Register map: word index = module * 16 + index, byte = word * 4
// ****************************************************************
`define ARF_ADDR_W          12
`define ARF_DATA_W          32
`define ARF_ACC_W           16
`define ARF_NUM_ACC         4
`define ARF_PTR_W           2
`define ARF_IDX_W           4
`define ARF_MOD_W           6
`define ARF_ACC_MODULE      6'h09
`define ARF_CTL_MODULE      6'h0a
`define ARF_ACC_ZERO_IDX    4'h0
`define ARF_ACC_ONE_IDX     4'h1
`define ARF_ACC_TWO_IDX     4'h2
`define ARF_ACC_THREE_IDX   4'h3
`define ARF_PTR_IDX         4'h0
`define ARF_OPER_IDX        4'h1
`define ARF_STAT_IDX        4'h2

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define ARF_ACC_RESET       16'h0000
`define ARF_PTR_RESET       2'h0
`define ARF_OPND_LSB        0
`define ARF_OPND_MSB        15
`define ARF_OPC_LSB         16
`define ARF_OPC_MSB         19
`define ARF_STAT_PTR_LSB    0
`define ARF_STAT_CARRY      2
`define ARF_STAT_ZERO       3

`endif

/* hw/arf_pkg.sv */
// Types shared by the accumulator register bank and its operation unit.
// Assumes arf_consts.svh is on the include path.
`include "arf_consts.svh"

package arf_pkg;

    // ****************************************************************
    // Operations on the selected accumulator
    // ****************************************************************
    typedef enum logic [3:0] {
        ARF_OP_LOAD = 4'b0000,
        ARF_OP_ADD  = 4'b0001,
        ARF_OP_SUB  = 4'b0010,
        ARF_OP_AND  = 4'b0011,
        ARF_OP_OR   = 4'b0100,
        ARF_OP_XOR  = 4'b0101,
        ARF_OP_CPL  = 4'b0110,
        ARF_OP_SHL  = 4'b0111,
        ARF_OP_SHR  = 4'b1000
    } arf_op_type;

endpackage

/* hw/arf_alu.sv */
// Arithmetic and logic unit working on the active accumulator.
// Assumes the caller registers result and carry; purely combinational.
`timescale 1ns/100ps
`include "arf_consts.svh"

module arf_alu
    import arf_pkg::*;
#(
    parameter int WIDTH = `ARF_ACC_W
) (
    input  wire logic [WIDTH-1:0] acc,       // Current accumulator value
    input  wire logic [WIDTH-1:0] operand,   // Second operand
    input  wire logic [3:0]       opcode,    // Operation select
    output logic      [WIDTH-1:0] result,    // Value written back
    output logic                  carry      // Carry or borrow out
);

    logic [WIDTH:0] sum;
    logic [WIDTH:0] diff;

    assign sum  = {1'b0, acc} + {1'b0, operand};
    assign diff = {1'b0, acc} - {1'b0, operand};

    always_comb begin
        result = acc;
        carry  = 1'b0;
        case (opcode)
            ARF_OP_LOAD: result = operand;
            ARF_OP_ADD: begin
                result = sum[WIDTH-1:0];
                carry  = sum[WIDTH];
            end
            ARF_OP_SUB: begin
                result = diff[WIDTH-1:0];
                carry  = diff[WIDTH];
            end
            ARF_OP_AND: result = acc & operand;
            ARF_OP_OR:  result = acc | operand;
            ARF_OP_XOR: result = acc ^ operand;
            ARF_OP_CPL: result = ~acc;
            ARF_OP_SHL: begin
                result = {acc[WIDTH-2:0], 1'b0};
                carry  = acc[WIDTH-1];
            end
            ARF_OP_SHR: begin
                result = {1'b0, acc[WIDTH-1:1]};
                carry  = acc[0];
            end
            default: result = acc;
        endcase
    end

endmodule // arf_alu

/* hw/arf_bank.sv */
// Bank of 16-bit accumulator registers with a pointer-selected active
// accumulator and an APB slave for software access.
// Assumes one clock, an APB master on the same clock, asynchronous
// active-low reset driven by every reset source of the core.
`timescale 1ns/100ps
`include "arf_consts.svh"

module arf_bank
    import arf_pkg::*;
#(
    parameter int NUM_ACC = `ARF_NUM_ACC,
    parameter int ACC_W   = `ARF_ACC_W
) (
    input  wire logic                    clk,      // Core clock, 200 MHz
    input  wire logic                    resetn,   // Async reset, active low
    input  wire logic                    psel,     // APB select
    input  wire logic                    penable,  // APB access phase
    input  wire logic                    pwrite,   // APB direction, high = write
    input  wire logic [`ARF_ADDR_W-1:0]  paddr,    // APB byte address
    input  wire logic [`ARF_DATA_W-1:0]  pwdata,   // APB write data
    output logic      [`ARF_DATA_W-1:0]  prdata,   // APB read data
    output logic                         pready,   // APB ready
    output logic                         pslverr   // APB error
);

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    function automatic logic hit(input logic [`ARF_ADDR_W-1:0] addr,
                                 input logic [`ARF_MOD_W-1:0]  module_no,
                                 input logic [`ARF_IDX_W-1:0]  index);
        hit = (addr[`ARF_ADDR_W-1:`ARF_IDX_W+2] == module_no)
            && (addr[`ARF_IDX_W+1:2] == index);
    endfunction

    logic                     access;
    logic                     done;
    logic                     wr_done;
    logic                     in_acc_module;
    logic [`ARF_IDX_W-1:0]    word_idx;
    logic                     acc_hit;
    logic                     ptr_hit;
    logic                     oper_hit;
    logic                     stat_hit;
    logic                     mapped;
    logic                     bad_write;

    assign access        = psel & penable;
    assign done          = access & pready;
    assign wr_done       = done & pwrite & ~pslverr;
    assign word_idx      = paddr[`ARF_IDX_W+1:2];
    assign in_acc_module = paddr[`ARF_ADDR_W-1:`ARF_IDX_W+2] == `ARF_ACC_MODULE;
    assign acc_hit       = in_acc_module && (word_idx < NUM_ACC[`ARF_IDX_W-1:0]);
    assign ptr_hit       = hit(paddr, `ARF_CTL_MODULE, `ARF_PTR_IDX);
    assign oper_hit      = hit(paddr, `ARF_CTL_MODULE, `ARF_OPER_IDX);
    assign stat_hit      = hit(paddr, `ARF_CTL_MODULE, `ARF_STAT_IDX);
    assign mapped        = acc_hit | ptr_hit | oper_hit | stat_hit;
    assign bad_write     = pwrite & stat_hit;

    // ****************************************************************
    // Pointer, operation and flag registers
    // ****************************************************************
    logic [`ARF_PTR_W-1:0]    acc_ptr;
    logic [`ARF_DATA_W-1:0]   last_oper;
    logic                     carry_flag;
    logic                     zero_flag;
    logic                     oper_go;
    logic                     ptr_we;
    logic [ACC_W-1:0]         operand;
    logic [3:0]               opcode;

    assign ptr_we  = wr_done & ptr_hit;
    assign oper_go = wr_done & oper_hit;
    assign operand = pwdata[`ARF_OPND_MSB:`ARF_OPND_LSB];
    assign opcode  = pwdata[`ARF_OPC_MSB:`ARF_OPC_LSB];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_ptr <= `ARF_PTR_RESET;
        end else if (ptr_we) begin
            acc_ptr <= pwdata[`ARF_PTR_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_oper <= '0;
        end else if (oper_go) begin
            last_oper <= pwdata;
        end
    end

    // ****************************************************************
    // Operation unit on the active accumulator
    // ****************************************************************
    logic [ACC_W-1:0]         acc_q [NUM_ACC];
    logic [ACC_W-1:0]         active_acc;
    logic [ACC_W-1:0]         alu_result;
    logic                     alu_carry;

    assign active_acc = acc_q[acc_ptr];

    arf_alu #(
        .WIDTH   (ACC_W)
    ) u_alu (
        .acc     (active_acc),
        .operand (operand),
        .opcode  (opcode),
        .result  (alu_result),
        .carry   (alu_carry)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            carry_flag <= 1'b0;
            zero_flag  <= 1'b0;
        end else if (oper_go) begin
            carry_flag <= alu_carry;
            zero_flag  <= (alu_result == '0);
        end
    end

    // ****************************************************************
    // Accumulator storage
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ACC; gi++) begin : g_acc
            logic sw_we;
            logic op_we;

            assign sw_we = wr_done && acc_hit && (word_idx == `ARF_IDX_W'(gi));
            assign op_we = oper_go && (acc_ptr == `ARF_PTR_W'(gi));

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    acc_q[gi] <= `ARF_ACC_RESET;
                end else if (sw_we) begin
                    acc_q[gi] <= pwdata[ACC_W-1:0];
                end else if (op_we) begin
                    acc_q[gi] <= alu_result;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Read data selection
    // ****************************************************************
    logic [`ARF_DATA_W-1:0]   acc_rd;
    logic [`ARF_DATA_W-1:0]   ptr_rd;
    logic [`ARF_DATA_W-1:0]   stat_rd;
    logic [`ARF_DATA_W-1:0]   next_prdata;

    assign acc_rd  = {{(`ARF_DATA_W-ACC_W){1'b0}}, acc_q[word_idx[`ARF_PTR_W-1:0]]};
    assign ptr_rd  = {{(`ARF_DATA_W-`ARF_PTR_W){1'b0}}, acc_ptr};
    // Status: pointer, carry and zero of the last operation
    assign stat_rd = {{(`ARF_DATA_W-`ARF_STAT_ZERO-1){1'b0}}, zero_flag, carry_flag, acc_ptr};

    assign next_prdata = (pwrite)   ? '0 :
                         (acc_hit)  ? acc_rd :
                         (ptr_hit)  ? ptr_rd :
                         (oper_hit) ? last_oper :
                         (stat_hit) ? stat_rd : '0;

    // ****************************************************************
    // APB answer: one wait cycle in every access phase
    // ****************************************************************
    logic                     answer;
    logic                     next_pslverr;

    // Second access cycle answers; the pulse lasts one cycle
    assign answer       = access & ~pready;
    assign next_pslverr = ~mapped | bad_write;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
        end else begin
            pready <= answer;
        end
    end

    // Read data stands only while pready is high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= '0;
        end else if (answer) begin
            prdata <= next_prdata;
        end else begin
            prdata <= '0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pslverr <= 1'b0;
        end else if (answer) begin
            pslverr <= next_pslverr;
        end else begin
            pslverr <= 1'b0;
        end
    end

endmodule // arf_bank

/* tb/arf_bank_asserts.sv */
// Concurrent checks on the APB side of the accumulator bank.
// Assumes it is bound to arf_bank and sees only that module's ports.
`timescale 1ns/100ps
module arf_bank_chk #(
    parameter int NUM_ACC = 4,
    parameter int ACC_W   = 16
) (
    input wire logic        clk,     // Core clock
    input wire logic        resetn,  // Reset, active low
    input wire logic        psel,    // Select
    input wire logic        penable, // Access phase
    input wire logic        pwrite,  // Direction
    input wire logic [11:0] paddr,   // Byte address
    input wire logic [31:0] pwdata,  // Write data
    input wire logic [31:0] prdata,  // Read data
    input wire logic        pready,  // Ready
    input wire logic        pslverr  // Error
);
    wire [9:0] word   = paddr[11:2];
    wire       is_acc = word >= 10'h090 && word < 10'h090 + NUM_ACC;
    wire       mapped = is_acc || (word >= 10'h0a0 && word <= 10'h0a2);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_lat_a: assert property ($rose(psel && penable) |=> pready)
        else $error("ready late");
    ready_cause_a: assert property (pready |-> $past(psel && penable) && psel)
        else $error("ready without access");
    idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    idle_err_a: assert property (!pready |-> !pslverr)
        else $error("error outside answer");
    unmapped_err_a: assert property (pready && !mapped |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    acc_read_a: assert property (pready && is_acc |-> !pslverr && prdata[31:ACC_W] == '0)
        else $error("accumulator access bad");
    ptr_read_a: assert property (pready && !pwrite && word == 10'h0a0 |-> !prdata[31:2])
        else $error("pointer read upper bits set");
endmodule // arf_bank_chk

bind arf_bank arf_bank_chk #(.NUM_ACC(NUM_ACC), .ACC_W(ACC_W)) chk (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* tb/arf_bank_test.sv */
// Self-checking bench for the accumulator bank over APB.
// Assumes arf_consts.svh on the include path and the checker bound in.
`timescale 1ns/100ps
`include "arf_consts.svh"
module arf_bank_test;
    import arf_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er;
    logic [15:0] exp_acc [4];
    logic [16:0] r;
    logic [15:0] b;
    int          mismatches = 0, checks = 0;
    always #2.5 clk = ~clk;
    arf_bank uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ****************
    // Tasks
    // ****************
    task complete_run;
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk_data(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_err(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk_data(rd, e);
        chk_err(er, 1'b0);
    endtask
    function automatic logic [11:0] adr(input int i);
        return 12'h240 + 12'(i * 4);
    endfunction
    function automatic logic [16:0] op_exp(input int c, input logic [15:0] a,
                                           input logic [15:0] b);
        case (c)
            0: return {1'b0, b};
            1: return 17'(a) + 17'(b);
            2: return {a < b, 16'(a - b)};
            3: return {1'b0, a & b};
            4: return {1'b0, a | b};
            5: return {1'b0, a ^ b};
            6: return {1'b0, ~a};
            7: return {a[15], a << 1};
            8: return {a[0], a >> 1};
            default: return {1'b0, a};
        endcase
    endfunction
    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) rdchk(adr(i), 32'h0000_0000);
        for (int i = 0; i < 4; i++) exp_acc[i] = 16'hffff - 16'(i);
        for (int i = 0; i < 4; i++) apb(1'b1, adr(i), {16'hffff, exp_acc[i]});
        for (int j = 0; j < 2; j++)
            for (int i = 0; i < 4; i++) rdchk(adr(i), {16'h0000, exp_acc[i]});
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, 12'h280, 32'(p));
            rdchk(12'h280, 32'(p));
            b = p[0] ? 16'hf00f : 16'h8421;
            for (int c = 0; c < 10; c++) begin
                apb(1'b1, adr(p), {16'h0000, 16'h8421});
                apb(1'b1, 12'h284, {12'h000, 4'(c), b});
                rdchk(12'h284, {12'h000, 4'(c), b});
                r = op_exp(c, 16'h8421, b);
                exp_acc[p] = r[15:0];
                rdchk(adr(p), {16'h0000, r[15:0]});
                rdchk(12'h288, 32'({r[15:0] == 16'h0000, r[16], 2'(p)}));
            end
            apb(1'b1, adr((p + 1) % 4), 32'h0000_0000);
            exp_acc[(p + 1) % 4] = 16'h0000;
            rdchk(12'h288, 32'({r[15:0] == 16'h0000, r[16], 2'(p)}));
            for (int i = 0; i < 4; i++) rdchk(adr(i), {16'h0000, exp_acc[i]});
        end
        apb(1'b0, 12'h250, 32'h0000_0000);
        chk_err(er, 1'b1);
        chk_data(rd, 32'h0000_0000);
        apb(1'b1, 12'h27c, 32'hffff_ffff);
        chk_err(er, 1'b1);
        apb(1'b1, 12'h288, 32'hffff_ffff);
        chk_err(er, 1'b1);
        rdchk(12'h288, 32'h0000_0003);
        for (int i = 0; i < 4; i++) rdchk(adr(i), {16'h0000, exp_acc[i]});
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) rdchk(adr(i), 32'h0000_0000);
        complete_run();
    end
endmodule // arf_bank_test
